// ---- src/serial2_pkg.sv ----
// shared constants and carrier types for the second serial port configuration block
package serial2_pkg;

    // bus widths and register index slice of the byte address
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BAUD_CONFIG  = 8'h8f;
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'hb1;
    localparam logic [7:0] IDX_PRIO_LOW     = 8'hb2;
    localparam logic [7:0] IDX_PRIO_HIGH    = 8'hb3;
    localparam logic [7:0] IDX_ADDR_MASK    = 8'hba;
    localparam logic [7:0] IDX_INDIV_ADDR   = 8'haa;
    localparam logic [7:0] IDX_PORT_CONTROL = 8'h98;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'hc0;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'hc1;

    // baud configuration fields; only the upper nibble is stored
    localparam int BAUD_DOUBLE_BIT = 7;
    localparam int TOP_SEL_BIT     = 6;
    localparam int RX_SRC_BIT      = 5;
    localparam int TX_SRC_BIT      = 4;
    localparam int BAUD_CFG_LSB    = 4;

    // single-bit enable and priority registers
    localparam int IRQ_ENABLE_BIT = 0;
    localparam int PRIO_BIT       = 0;

    // port control fields
    localparam int PC_TOP_BIT   = 7;
    localparam int PC_MODE1_BIT = 6;
    localparam int PC_MULTI_BIT = 5;
    localparam int PC_RXEN_BIT  = 4;
    localparam int PC_TB8_BIT   = 3;
    localparam int PC_TI_BIT    = 1;
    localparam int PC_RI_BIT    = 0;

    // interrupt status and mask fields
    localparam int ST_W     = 3;
    localparam int ST_TX    = 0;
    localparam int ST_RX    = 1;
    localparam int ST_FE    = 2;

    // reset values
    localparam logic [7:0]      ADDR_MASK_RST  = 8'h00;
    localparam logic [7:0]      INDIV_ADDR_RST = 8'h00;
    localparam logic [3:0]      BAUD_CFG_RST   = 4'h0;
    localparam logic [6:0]      PC_LOW_RST     = 7'h00;
    localparam logic [ST_W-1:0] STATUS_RST     = 3'h0;

    // serial operating modes
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_UART8 = 2'h1,
        MODE_UART9 = 2'h2,
        MODE_UART9V = 2'h3
    } serial_mode_t;

    // apb request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } apb_rsp_t;

endpackage : serial2_pkg

// ---- src/baud_tick_select.sv ----
// baud tick source selection and optional halving for one direction
module baud_tick_select (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    // timer overflow pulses
    input  wire logic timer1_ovf_in,
    input  wire logic timer2_ovf_in,
    // configuration
    input  wire logic use_timer2_in,
    input  wire logic active_in,
    input  wire logic double_in,
    // baud tick
    output logic      tick_out
);

    typedef struct packed {
        logic half;
        logic tick;
    } sel_state_t;

    sel_state_t s;
    sel_state_t next_s;

    // pick the overflow source; timer 1 is halved unless doubling is on
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!active_in) begin
            next_s.half = 1'b0;
        end else if (use_timer2_in) begin
            next_s.tick = timer2_ovf_in;
        end else if (timer1_ovf_in) begin
            if (double_in) begin
                next_s.tick = 1'b1;
            end else begin
                next_s.tick = s.half;
                next_s.half = ~s.half;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

endmodule : baud_tick_select

// ---- src/second_serial_port_config.sv ----
// configuration, baud selection, address mask and interrupt control of the second serial port
module second_serial_port_config (
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     rstn_in,
    // register bus
    input  wire serial2_pkg::apb_req_t    apb_in,
    output serial2_pkg::apb_rsp_t         apb_out,
    // events and data from the shift datapath
    input  wire logic                     tx_done_in,
    input  wire logic                     rx_done_in,
    input  wire logic                     framing_err_in,
    input  wire logic [7:0]               rx_addr_in,
    // timer overflow pulses
    input  wire logic                     timer1_ovf_in,
    input  wire logic                     timer2_ovf_in,
    // baud ticks and configuration to the datapath
    output logic                          rx_baud_tick_out,
    output logic                          tx_baud_tick_out,
    output logic                          baud_double_out,
    output serial2_pkg::serial_mode_t     serial_mode_out,
    output logic                          multiproc_out,
    output logic                          rx_enable_out,
    output logic                          tx_bit8_out,
    // address recognition
    output logic [7:0]                    given_addr_out,
    output logic                          addr_match_out,
    // interrupt controller and interrupt line
    output logic                          irq_request_out,
    output logic [1:0]                    irq_priority_out,
    output logic                          irq_out
);

    typedef struct packed {
        logic [7:0]                  addr_mask;
        logic [7:0]                  indiv_addr;
        logic [3:0]                  baud_cfg;
        logic                        irq_en;
        logic                        prio_low;
        logic                        prio_high;
        logic                        mode0;
        logic                        fe;
        logic [6:0]                  pc_low;
        logic [serial2_pkg::ST_W-1:0] status;
        logic [serial2_pkg::ST_W-1:0] mask;
        serial2_pkg::apb_rsp_t       rsp;
        logic [7:0]                  given_addr;
        logic                        addr_match;
        logic                        irq_req;
        logic                        irq;
    } cfg_state_t;

    cfg_state_t s;
    cfg_state_t next_s;

    logic [7:0]                   idx;
    logic                         addr_ok;
    logic                         setup;
    logic                         wr;
    logic [7:0]                   wdata;
    logic [7:0]                   rd_val;
    logic                         rd_hit;
    logic [serial2_pkg::ST_W-1:0] events;
    logic                         double_bit;
    logic                         top_sel;
    logic                         uart_timed;

    // bus decode; only aligned words inside the index window are mapped
    assign idx     = apb_in.paddr[serial2_pkg::IDX_MSB:serial2_pkg::IDX_LSB];
    assign addr_ok = (apb_in.paddr[serial2_pkg::ADDR_W-1:serial2_pkg::IDX_MSB+1] == '0)
                   && (apb_in.paddr[serial2_pkg::IDX_LSB-1:0] == '0);
    assign setup   = apb_in.psel & ~apb_in.penable;
    assign wr      = apb_in.psel & apb_in.penable & s.rsp.pready & apb_in.pwrite & apb_in.pstrb[0];
    assign wdata   = apb_in.pwdata[7:0];

    // frequently used configuration bits
    assign double_bit = s.baud_cfg[serial2_pkg::BAUD_DOUBLE_BIT-serial2_pkg::BAUD_CFG_LSB];
    assign top_sel    = s.baud_cfg[serial2_pkg::TOP_SEL_BIT-serial2_pkg::BAUD_CFG_LSB];
    assign uart_timed = s.pc_low[serial2_pkg::PC_MODE1_BIT];   // modes 1 and 3 use timer ticks
    assign events     = {framing_err_in, rx_done_in, tx_done_in};

    // read multiplexer; reserved bits read as zero except port control bit 2, which reads back as written
    always_comb begin
        rd_val = 8'h00;
        rd_hit = addr_ok;
        case (idx)
            serial2_pkg::IDX_BAUD_CONFIG: begin
                rd_val = {s.baud_cfg, 4'h0};
            end
            serial2_pkg::IDX_IRQ_ENABLE: begin
                rd_val[serial2_pkg::IRQ_ENABLE_BIT] = s.irq_en;
            end
            serial2_pkg::IDX_PRIO_LOW: begin
                rd_val[serial2_pkg::PRIO_BIT] = s.prio_low;
            end
            serial2_pkg::IDX_PRIO_HIGH: begin
                rd_val[serial2_pkg::PRIO_BIT] = s.prio_high;
            end
            serial2_pkg::IDX_ADDR_MASK: begin
                rd_val = s.addr_mask;
            end
            serial2_pkg::IDX_INDIV_ADDR: begin
                rd_val = s.indiv_addr;
            end
            serial2_pkg::IDX_PORT_CONTROL: begin
                rd_val = {(top_sel ? s.fe : s.mode0), s.pc_low};
            end
            serial2_pkg::IDX_IRQ_STATUS: begin
                rd_val[serial2_pkg::ST_W-1:0] = s.status;
            end
            serial2_pkg::IDX_IRQ_MASK: begin
                rd_val[serial2_pkg::ST_W-1:0] = s.mask;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // next state: bus answer, register writes, hardware flag sets
    always_comb begin
        next_s = s;
        next_s.rsp.pready = setup;
        if (setup) begin
            next_s.rsp.prdata  = {{(serial2_pkg::DATA_W-8){1'b0}}, rd_hit ? rd_val : 8'h00};
            next_s.rsp.pslverr = ~rd_hit;
        end
        if (wr && addr_ok) begin
            case (idx)
                serial2_pkg::IDX_BAUD_CONFIG: begin
                    next_s.baud_cfg = wdata[7:serial2_pkg::BAUD_CFG_LSB];
                end
                serial2_pkg::IDX_IRQ_ENABLE: begin
                    next_s.irq_en = wdata[serial2_pkg::IRQ_ENABLE_BIT];
                end
                serial2_pkg::IDX_PRIO_LOW: begin
                    next_s.prio_low = wdata[serial2_pkg::PRIO_BIT];
                end
                serial2_pkg::IDX_PRIO_HIGH: begin
                    next_s.prio_high = wdata[serial2_pkg::PRIO_BIT];
                end
                serial2_pkg::IDX_ADDR_MASK: begin
                    next_s.addr_mask = wdata;
                end
                serial2_pkg::IDX_INDIV_ADDR: begin
                    next_s.indiv_addr = wdata;
                end
                serial2_pkg::IDX_PORT_CONTROL: begin
                    next_s.pc_low = wdata[6:0];
                    if (top_sel) begin
                        next_s.fe = wdata[serial2_pkg::PC_TOP_BIT];
                    end else begin
                        next_s.mode0 = wdata[serial2_pkg::PC_TOP_BIT];
                    end
                end
                serial2_pkg::IDX_IRQ_STATUS: begin
                    next_s.status = s.status & ~wdata[serial2_pkg::ST_W-1:0];
                end
                serial2_pkg::IDX_IRQ_MASK: begin
                    next_s.mask = wdata[serial2_pkg::ST_W-1:0];
                end
                default: begin
                    next_s.status = next_s.status;
                end
            endcase
        end
        // hardware sets are applied last so they win over a software clear
        if (tx_done_in) begin
            next_s.pc_low[serial2_pkg::PC_TI_BIT] = 1'b1;
        end
        if (rx_done_in) begin
            next_s.pc_low[serial2_pkg::PC_RI_BIT] = 1'b1;
        end
        if (framing_err_in) begin
            next_s.fe = 1'b1;
        end
        next_s.status = next_s.status | events;
        // derived outputs, registered
        next_s.given_addr = s.indiv_addr & s.addr_mask;
        next_s.addr_match = ((rx_addr_in ^ s.indiv_addr) & s.addr_mask) == 8'h00;
        next_s.irq_req    = s.irq_en & (s.pc_low[serial2_pkg::PC_TI_BIT]
                                      | s.pc_low[serial2_pkg::PC_RI_BIT]);
        next_s.irq        = |(s.status & s.mask);
    end

    // state register with reset values
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s            <= '0;
            s.addr_mask  <= serial2_pkg::ADDR_MASK_RST;
            s.indiv_addr <= serial2_pkg::INDIV_ADDR_RST;
            s.baud_cfg   <= serial2_pkg::BAUD_CFG_RST;
            s.irq_en     <= 1'b0;
            s.prio_low   <= 1'b0;
            s.prio_high  <= 1'b0;
            s.pc_low     <= serial2_pkg::PC_LOW_RST;
            s.status     <= serial2_pkg::STATUS_RST;
            s.mask       <= serial2_pkg::STATUS_RST;
        end else begin
            s <= next_s;
        end
    end

    // receive tick: timer 2 or timer 1 in modes 1 and 3
    baud_tick_select rx_sel (
        .ref_clk_in    (ref_clk_in),
        .rstn_in       (rstn_in),
        .timer1_ovf_in (timer1_ovf_in),
        .timer2_ovf_in (timer2_ovf_in),
        .use_timer2_in (s.baud_cfg[serial2_pkg::RX_SRC_BIT-serial2_pkg::BAUD_CFG_LSB]),
        .active_in     (uart_timed),
        .double_in     (double_bit),
        .tick_out      (rx_baud_tick_out)
    );

    // transmit tick: timer 2 or timer 1 in modes 1 and 3
    baud_tick_select tx_sel (
        .ref_clk_in    (ref_clk_in),
        .rstn_in       (rstn_in),
        .timer1_ovf_in (timer1_ovf_in),
        .timer2_ovf_in (timer2_ovf_in),
        .use_timer2_in (s.baud_cfg[serial2_pkg::TX_SRC_BIT-serial2_pkg::BAUD_CFG_LSB]),
        .active_in     (uart_timed),
        .double_in     (double_bit),
        .tick_out      (tx_baud_tick_out)
    );

    // rate select for the datapath in modes 1, 2 and 3; held low in mode 0
    logic double_q;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            double_q <= 1'b0;
        end else begin
            double_q <= double_bit & (s.mode0 | s.pc_low[serial2_pkg::PC_MODE1_BIT]);
        end
    end

    // output assignments, all from flip-flops
    assign apb_out          = s.rsp;
    assign baud_double_out  = double_q;
    assign serial_mode_out  = serial2_pkg::serial_mode_t'({s.mode0, s.pc_low[serial2_pkg::PC_MODE1_BIT]});
    assign multiproc_out    = s.pc_low[serial2_pkg::PC_MULTI_BIT];
    assign rx_enable_out    = s.pc_low[serial2_pkg::PC_RXEN_BIT];
    assign tx_bit8_out      = s.pc_low[serial2_pkg::PC_TB8_BIT];
    assign given_addr_out   = s.given_addr;
    assign addr_match_out   = s.addr_match;
    assign irq_request_out  = s.irq_req;
    assign irq_priority_out = {s.prio_high, s.prio_low};
    assign irq_out          = s.irq;

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    logic rd_pc;
    logic rd_bc;
    assign rd_pc = setup && !apb_in.pwrite && addr_ok && idx == serial2_pkg::IDX_PORT_CONTROL;
    assign rd_bc = setup && !apb_in.pwrite && addr_ok && idx == serial2_pkg::IDX_BAUD_CONFIG;

    given_addr_a: assert property (##1 given_addr_out == ($past(s.indiv_addr) & $past(s.addr_mask))
        ) else $error("given address not masked individual address");
    reset_values_a: assert property ($rose(rstn_in) |-> s.addr_mask == 8'h00 && s.indiv_addr == 8'h00
        && s.baud_cfg == 4'h0 && !s.irq_en && irq_priority_out == 2'h0) else $error("bad reset values");
    double_tick_a: assert property (uart_timed && double_bit && !s.baud_cfg[0] && timer1_ovf_in
        && $stable(s.baud_cfg) |=> tx_baud_tick_out) else $error("doubled timer 1 tick missing");
    top_bit_read_a: assert property (rd_pc |=> apb_out.pready && apb_out.prdata[7] ==
        ($past(top_sel) ? $past(s.fe) : $past(s.mode0))) else $error("top bit read steered wrong");
    rx_source_a: assert property (uart_timed && s.baud_cfg[1] && timer2_ovf_in |=> rx_baud_tick_out
        ) else $error("receive tick not from timer 2");
    tx_source_a: assert property (uart_timed && !s.baud_cfg[0] && !timer1_ovf_in |=> !tx_baud_tick_out
        ) else $error("transmit tick without timer 1 overflow");
    reserved_read_a: assert property (rd_bc |=> apb_out.prdata[3:0] == 4'h0 && !apb_out.pslverr
        ) else $error("reserved baud bits not zero");
    irq_gate_a: assert property (!s.irq_en [*2] |-> !irq_request_out)
        else $error("request passed while disabled");
    priority_a: assert property (wr && addr_ok && idx == serial2_pkg::IDX_PRIO_HIGH |=>
        irq_priority_out[1] == $past(wdata[serial2_pkg::PRIO_BIT])) else $error("priority high bit mismatch");
    irq_request_a: assert property (s.irq_en && s.pc_low[serial2_pkg::PC_RI_BIT] |=> irq_request_out
        ) else $error("request missing with receive flag");
    sticky_set_a: assert property (tx_done_in |=> s.status[serial2_pkg::ST_TX] && s.pc_low[serial2_pkg::PC_TI_BIT]
        ) else $error("transmit event lost");
    one_cycle_ready_a: assert property (setup |=> apb_out.pready ##1 !apb_out.pready || setup
        ) else $error("ready not one cycle after setup");

    rx_t2_c: cover property (uart_timed && s.baud_cfg[1] ##1 rx_baud_tick_out);
    double_c: cover property (double_bit && uart_timed ##1 tx_baud_tick_out);
    irq_c: cover property (irq_request_out && irq_priority_out == 2'h3);
    fe_read_c: cover property (rd_pc && top_sel && s.fe);

endmodule : second_serial_port_config

// ---- testbench/serial2_peer_model.sv ----
// model of the shift datapath and timers feeding the port configuration block
module serial2_peer_model (
    // clock
    input  wire logic       ref_clk_in,
    // datapath events and received address
    output logic            tx_done_out,
    output logic            rx_done_out,
    output logic            framing_err_out,
    output logic [7:0]      rx_addr_out,
    // timer overflow pulses
    output logic            timer1_ovf_out,
    output logic            timer2_ovf_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle at time zero
    initial begin
        {tx_done_out, rx_done_out, framing_err_out, timer1_ovf_out, timer2_ovf_out} = 5'h00;
        rx_addr_out = 8'h00;
    end

    // one-cycle pulse on {tx, rx, framing, timer1, timer2}
    task automatic fire(input logic [4:0] ev);
        @(posedge ref_clk_in);
        {tx_done_out, rx_done_out, framing_err_out, timer1_ovf_out, timer2_ovf_out} <= ev;
        @(posedge ref_clk_in);
        {tx_done_out, rx_done_out, framing_err_out, timer1_ovf_out, timer2_ovf_out} <= 5'h00;
    endtask : fire

    // present a received address byte
    task automatic set_addr(input logic [7:0] a);
        @(posedge ref_clk_in);
        rx_addr_out <= a;
    endtask : set_addr
endmodule : serial2_peer_model

// ---- testbench/tb_second_serial_port_config.sv ----
// self-checking bench of the second serial port configuration block
module tb_second_serial_port_config;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      ref_clk_in = 1'b0;
    logic                      rstn_in    = 1'b0;
    serial2_pkg::apb_req_t     apb_req    = '0;
    serial2_pkg::apb_rsp_t     apb_rsp;
    serial2_pkg::serial_mode_t mode;
    logic                      tx_done, rx_done, fe, t1, t2, rx_tick, tx_tick, dbl, match, irq_req, irq;
    logic [7:0]                rx_addr, given;
    logic [1:0]                prio;
    logic [31:0]               rdata;
    logic                      rerr, mp, ren, tb8;
    logic [3:0]                strb       = 4'hf;
    int                        n_errors = 0, n_checks = 0, n_rx = 0, n_tx = 0, r0, x0;
    logic [7:0]                regs [6] = '{serial2_pkg::IDX_BAUD_CONFIG, serial2_pkg::IDX_IRQ_ENABLE,
                                           serial2_pkg::IDX_PRIO_LOW, serial2_pkg::IDX_PRIO_HIGH,
                                           serial2_pkg::IDX_ADDR_MASK, serial2_pkg::IDX_INDIV_ADDR};

    // clock and baud tick counters
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        n_rx <= n_rx + int'(rx_tick === 1'b1);
        n_tx <= n_tx + int'(tx_tick === 1'b1);
    end

    second_serial_port_config i_second_serial_port_config (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .apb_in(apb_req), .apb_out(apb_rsp),
        .tx_done_in(tx_done), .rx_done_in(rx_done), .framing_err_in(fe), .rx_addr_in(rx_addr),
        .timer1_ovf_in(t1), .timer2_ovf_in(t2), .rx_baud_tick_out(rx_tick), .tx_baud_tick_out(tx_tick),
        .baud_double_out(dbl), .serial_mode_out(mode), .multiproc_out(mp), .rx_enable_out(ren),
        .tx_bit8_out(tb8), .given_addr_out(given), .addr_match_out(match), .irq_request_out(irq_req),
        .irq_priority_out(prio), .irq_out(irq));

    serial2_peer_model i_serial2_peer_model (
        .ref_clk_in(ref_clk_in), .tx_done_out(tx_done), .rx_done_out(rx_done), .framing_err_out(fe),
        .rx_addr_out(rx_addr), .timer1_ovf_out(t1), .timer2_ovf_out(t2));

    // comparison and verdict
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // one apb transfer, waiting a bounded time for pready
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge ref_clk_in);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'h0, idx, 2'h0}, pwdata: d, pstrb: strb};
        @(posedge ref_clk_in);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            summarize();
        end
        rdata = apb_rsp.prdata;
        rerr  = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx);
        apb(1'b0, idx, 32'h0);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : cyc

    // main sequence
    initial begin
        cyc(2);
        rstn_in <= 1'b1;
        // reset values and reserved bits
        foreach (regs[i]) begin
            rd(regs[i]);
            chk("reset value", rdata, 32'h0);
        end
        chk("reset priority", {30'h0, prio}, 32'h0);
        rd(8'h00);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        wr(serial2_pkg::IDX_BAUD_CONFIG, 32'hff);
        rd(serial2_pkg::IDX_BAUD_CONFIG);
        chk("baud config", rdata, 32'hf0);
        wr(serial2_pkg::IDX_BAUD_CONFIG, 32'h00);
        // address under mask
        wr(serial2_pkg::IDX_INDIV_ADDR, 32'ha5);
        wr(serial2_pkg::IDX_ADDR_MASK, 32'h0f);
        i_serial2_peer_model.set_addr(8'h35);
        cyc(2);
        chk("given address", {24'h0, given}, 32'h05);
        chk("match masked", {31'h0, match}, 32'h1);
        i_serial2_peer_model.set_addr(8'h34);
        cyc(2);
        chk("no match", {31'h0, match}, 32'h0);
        // all four priority levels
        for (int p = 0; p < 4; p++) begin
            wr(serial2_pkg::IDX_PRIO_HIGH, 32'(p >> 1));
            wr(serial2_pkg::IDX_PRIO_LOW, 32'(p & 1));
            cyc(2);
            chk("priority", {30'h0, prio}, 32'(p));
        end
        // top bit steering
        wr(serial2_pkg::IDX_PORT_CONTROL, 32'h80);
        cyc(2);
        chk("mode via top bit", {30'h0, mode}, 32'h2);
        wr(serial2_pkg::IDX_BAUD_CONFIG, 32'h40);
        rd(serial2_pkg::IDX_PORT_CONTROL);
        chk("framing flag clear", {31'h0, rdata[7]}, 32'h0);
        i_serial2_peer_model.fire(5'h04);
        rd(serial2_pkg::IDX_PORT_CONTROL);
        chk("framing flag set", {31'h0, rdata[7]}, 32'h1);
        chk("mode kept", {30'h0, mode}, 32'h2);
        wr(serial2_pkg::IDX_BAUD_CONFIG, 32'h00);
        // mode 1: rx from timer 2, tx from timer 1 halved, then doubled
        wr(serial2_pkg::IDX_PORT_CONTROL, 32'h40);
        wr(serial2_pkg::IDX_BAUD_CONFIG, 32'h20);
        r0 = n_rx;
        x0 = n_tx;
        i_serial2_peer_model.fire(5'h01);
        i_serial2_peer_model.fire(5'h02);
        i_serial2_peer_model.fire(5'h02);
        cyc(3);
        chk("rx ticks", 32'(n_rx - r0), 32'h1);
        chk("tx ticks halved", 32'(n_tx - x0), 32'h1);
        wr(serial2_pkg::IDX_BAUD_CONFIG, 32'ha0);
        x0 = n_tx;
        i_serial2_peer_model.fire(5'h02);
        i_serial2_peer_model.fire(5'h02);
        cyc(3);
        chk("tx ticks doubled", 32'(n_tx - x0), 32'h2);
        chk("double out", {31'h0, dbl}, 32'h1);
        wr(serial2_pkg::IDX_PORT_CONTROL, 32'h00);
        r0 = n_rx;
        i_serial2_peer_model.fire(5'h01);
        cyc(3);
        chk("no ticks mode 0", 32'(n_rx - r0), 32'h0);
        chk("no double mode 0", {31'h0, dbl}, 32'h0);
        // port request, status, mask and clear
        wr(serial2_pkg::IDX_IRQ_ENABLE, 32'h1);
        i_serial2_peer_model.fire(5'h10);
        cyc(2);
        chk("request on", {31'h0, irq_req}, 32'h1);
        wr(serial2_pkg::IDX_IRQ_ENABLE, 32'h0);
        cyc(2);
        chk("request gated", {31'h0, irq_req}, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(serial2_pkg::IDX_IRQ_MASK, 32'h1);
        cyc(2);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(serial2_pkg::IDX_IRQ_STATUS, 32'h1);
        cyc(2);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rd(serial2_pkg::IDX_IRQ_STATUS);
        chk("status left", rdata, 32'h4);
        // write without the low byte strobe is ignored
        strb = 4'he;
        wr(serial2_pkg::IDX_ADDR_MASK, 32'hff);
        strb = 4'hf;
        rd(serial2_pkg::IDX_ADDR_MASK);
        chk("strobe off write", rdata, 32'h0f);
        // port control fields, then request from the receive flag
        wr(serial2_pkg::IDX_PORT_CONTROL, 32'h38);
        cyc(2);
        chk("control fields", {29'h0, mp, ren, tb8}, 32'h7);
        wr(serial2_pkg::IDX_IRQ_ENABLE, 32'h1);
        cyc(2);
        chk("no request idle", {31'h0, irq_req}, 32'h0);
        i_serial2_peer_model.fire(5'h08);
        cyc(2);
        chk("request on receive", {31'h0, irq_req}, 32'h1);
        rd(serial2_pkg::IDX_IRQ_STATUS);
        chk("status receive", rdata, 32'h6);
        summarize();
    end
endmodule : tb_second_serial_port_config
